/* File: protect_params.svh */
/*
  offsets, field positions, reset values and timing figures for the
  protection enable and charge-switch mask bank.
  assumes: included by bare name from the package and the design files.
*/
`ifndef PROTECT_PARAMS_SVH
`define PROTECT_PARAMS_SVH

// register byte offsets on the bus
`define OFS_TEMP_EN      8'h00
`define OFS_LATCH_EN     8'h04
`define OFS_CHG_MASK_A   8'h08
`define OFS_CHG_MASK_B   8'h0C
`define OFS_SAFETY       8'h10
`define OFS_IRQ_STATUS   8'h14
`define OFS_IRQ_CLEAR    8'h18
`define OFS_IRQ_ENABLE   8'h1C

// reset values
`define RST_TEMP_EN      8'h00
`define RST_LATCH_EN     8'h00
`define RST_CHG_MASK_A   8'h98
`define RST_CHG_MASK_B   8'hD5
`define RST_IRQ          16'h0000

// writable bits; reserved bits stay zero
`define WR_TEMP_EN       8'hF7
`define WR_LATCH_EN      8'hF6
`define WR_CHG_MASK_A    8'h98
`define WR_CHG_MASK_B    8'hD5

// mask values that give immediate turn-off
`define FAST_MASK_A0     8'h98
`define FAST_MASK_A1     8'h18

// field positions
`define BIT_SWITCH_OVERHEAT    7
`define BIT_DISCHARGE_SHORT    7
`define BIT_CHARGE_OVERCURRENT 4
`define BIT_CELL_OVERVOLTAGE   3

// deferred turn-off bounds, and the clock rate
`define DEFER_NORMAL_MS  250
`define DEFER_SLEEP_MS   1000
`define CLK_KHZ          10000

`endif

/* File: protect_pkg.sv */
/*
  types shared by the protection bank and its tick timer.
  assumes: protect_params.svh is on the include path.
*/
package protect_pkg;
  `include "protect_params.svh"

  typedef enum logic [1:0] {
    HT_IDLE,
    HT_BUSY,
    HT_NONSEQ,
    HT_SEQ
  } htrans_t;

  typedef logic [7:0]  field_t;
  typedef logic [15:0] flags_t;
  typedef logic [23:0] period_t;
endpackage

/* File: period_tick.sv */
/*
  free running down-counter that gives one pulse per period.
  assumes: period is at least one; it may change at any time.
*/
`timescale 1ns/1ns
module period_tick (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset_n,
  // period and pulse
  input  wire protect_pkg::period_t period,
  output logic                    tick
);
  import protect_pkg::*;

  period_t cnt_q;   // cycles left in this period
  period_t cnt_d;
  logic    done;    // count reached zero

  // a shorter period cuts a long count short, so the bound always holds
  assign done  = (cnt_q == 24'h00_0000) || (cnt_q >= period);
  assign cnt_d = done ? period - 24'h00_0001 : cnt_q - 24'h00_0001;
  assign tick  = done;

  // count down, reload on expiry
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 24'h00_0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

/* File: protect_bank.sv */
/*
  protection enable and charge-switch mask bank with an ahb-lite slave,
  safety flags, charge-switch turn-off and a level interrupt.
  assumes: fault triggers and sleep_mode are synchronous to clk; single
  word transfers only; this is the only slave on its bus.
*/
`timescale 1ns/1ns
`include "protect_params.svh"

// Summary of operation
// - enabled detected fault sets its safety flag
// - enables never drive the charge switch
// - temperature enables, bit 3 reserved, reset zero
// - latch enables, bits 3 and 0 reserved
// - mask a bits 7,4,3 turn switch off
// - mask 0x98 or 0x18 turns off immediately
// - other mask a values defer, bounded delay
// - mask b temperature bits turn switch off
// - each mask bit acts on its own
module protect_bank #(
  parameter protect_pkg::period_t NORMAL_CYC = 24'(`DEFER_NORMAL_MS * `CLK_KHZ),
  parameter protect_pkg::period_t SLEEP_CYC  = 24'(`DEFER_SLEEP_MS * `CLK_KHZ)
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire protect_pkg::htrans_t htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // fault triggers from the detectors
  input  wire protect_pkg::field_t  fault_current,
  input  wire protect_pkg::field_t  fault_temp,
  input  wire protect_pkg::field_t  fault_latch,
  input  wire logic                 sleep_mode,
  // safety flags and switch drive
  output protect_pkg::field_t       safety_temp,
  output protect_pkg::field_t       safety_latch,
  output logic                      charge_switch_off,
  // interrupt
  output logic                      irq
);
  import protect_pkg::*;

  // configuration registers
  field_t  temp_en_q;     // temperature protection enables
  field_t  latch_en_q;    // latch and timeout enables
  field_t  mask_a_q;      // current/voltage charge-switch mask
  field_t  mask_b_q;      // temperature charge-switch mask
  field_t  temp_en_d;
  field_t  latch_en_d;
  field_t  mask_a_d;
  field_t  mask_b_d;

  // flags and interrupt state
  field_t  safe_t_q;      // temperature safety flags
  field_t  safe_l_q;      // latch safety flags
  field_t  safe_t_d;
  field_t  safe_l_d;
  flags_t  irq_st_q;      // sticky event bits
  flags_t  irq_en_q;      // interrupt enables
  flags_t  irq_st_d;
  flags_t  irq_en_d;
  flags_t  events;        // new flags this cycle
  flags_t  irq_clr;       // write-one-to-clear pulse
  logic    irq_d;

  // bus state
  logic        wr_q;      // data phase of a write
  logic [7:0]  addr_q;    // latched word address
  logic        ahb_go;    // address phase accepted
  logic        wen;       // write commits this cycle
  logic        sel_temp;
  logic        sel_latch;
  logic        sel_ma;
  logic        sel_mb;
  logic        sel_clr;
  logic        sel_ien;
  logic [31:0] rdata_d;
  logic [31:0] hrdata_q;
  logic        hready_q;
  logic        hresp_q;

  // charge-switch path
  field_t  hit_a;         // current/voltage faults selected by mask a
  field_t  hit_b;         // temperature flags selected by mask b
  logic    fast_mask;     // mask a allows immediate action
  logic    off_now;       // immediate turn-off request
  logic    defer_q;       // deferred turn-off, sampled on tick
  logic    defer_d;
  logic    off_q;
  logic    off_d;
  logic    tick;
  period_t period;

  // address phase taken while the bus is ready
  assign ahb_go = hsel && hready && (htrans == HT_NONSEQ || htrans == HT_SEQ);
  assign wen    = wr_q;

  // write decode in the data phase
  assign sel_temp  = wen && (addr_q == `OFS_TEMP_EN);
  assign sel_latch = wen && (addr_q == `OFS_LATCH_EN);
  assign sel_ma    = wen && (addr_q == `OFS_CHG_MASK_A);
  assign sel_mb    = wen && (addr_q == `OFS_CHG_MASK_B);
  assign sel_clr   = wen && (addr_q == `OFS_IRQ_CLEAR);
  assign sel_ien   = wen && (addr_q == `OFS_IRQ_ENABLE);

  // reserved positions dropped on write
  assign temp_en_d  = sel_temp  ? (hwdata[7:0] & `WR_TEMP_EN) : temp_en_q;
  assign latch_en_d = sel_latch ? (hwdata[7:0] & `WR_LATCH_EN) : latch_en_q;
  assign mask_a_d   = sel_ma    ? (hwdata[7:0] & `WR_CHG_MASK_A) : mask_a_q;
  assign mask_b_d   = sel_mb    ? (hwdata[7:0] & `WR_CHG_MASK_B) : mask_b_q;
  assign irq_en_d   = sel_ien   ? hwdata[15:0] : irq_en_q;
  assign irq_clr    = sel_clr   ? hwdata[15:0] : 16'h0000;

  // safety flags follow enabled detections only
  assign safe_t_d = fault_temp  & temp_en_q;
  assign safe_l_d = fault_latch & latch_en_q;

  // events are rising flags; a set in the clear cycle wins
  assign events   = {safe_l_d & ~safe_l_q, safe_t_d & ~safe_t_q};
  assign irq_st_d = (irq_st_q & ~irq_clr) | events;
  assign irq_d    = |(irq_st_d & irq_en_d);

  // read mux looks at next values so a read right after a write sees it
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (ahb_go && !hwrite) begin
      case (haddr[7:0])
        `OFS_TEMP_EN:    rdata_d = {24'h00_0000, temp_en_d};
        `OFS_LATCH_EN:   rdata_d = {24'h00_0000, latch_en_d};
        `OFS_CHG_MASK_A: rdata_d = {24'h00_0000, mask_a_d};
        `OFS_CHG_MASK_B: rdata_d = {24'h00_0000, mask_b_d};
        `OFS_SAFETY:     rdata_d = {16'h0000, safe_l_d, safe_t_d};
        `OFS_IRQ_STATUS: rdata_d = {16'h0000, irq_st_d};
        `OFS_IRQ_ENABLE: rdata_d = {16'h0000, irq_en_d};
        default:         rdata_d = 32'h0000_0000;   // unmapped and clear read zero
      endcase
    end
  end

  // each mask bit gates its own fault, no cross terms
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_mask
      assign hit_a[i] = fault_current[i] & mask_a_q[i];
      assign hit_b[i] = safe_t_d[i] & mask_b_q[i];
    end
  endgenerate

  // only the two documented values give same-cycle action
  assign fast_mask = (mask_a_q == `FAST_MASK_A0) || (mask_a_q == `FAST_MASK_A1);
  assign off_now   = |hit_b || (fast_mask && |hit_a);

  // deferred path sampled once per period; trades latency for a slow scan
  assign defer_d = tick ? (!fast_mask && |hit_a) : (defer_q && |hit_a);
  assign off_d   = off_now || defer_d;
  assign period  = sleep_mode ? SLEEP_CYC : NORMAL_CYC;

  // scan period for the deferred turn-off
  period_tick u_tick (
    .clk     (clk),
    .reset_n (reset_n),
    .period  (period),
    .tick    (tick)
  );

  // bus phase capture
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q   <= ahb_go && hwrite;
      addr_q <= ahb_go ? {haddr[7:2], 2'b00} : addr_q;
    end
  end

  // bus answer: zero wait, always okay
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata_q <= 32'h0000_0000;
      hready_q <= 1'b0;
      hresp_q  <= 1'b0;
    end else begin
      hrdata_q <= rdata_d;
      hready_q <= 1'b1;
      hresp_q  <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      temp_en_q  <= `RST_TEMP_EN;
      latch_en_q <= `RST_LATCH_EN;
      mask_a_q   <= `RST_CHG_MASK_A;
      mask_b_q   <= `RST_CHG_MASK_B;
    end else begin
      temp_en_q  <= temp_en_d;
      latch_en_q <= latch_en_d;
      mask_a_q   <= mask_a_d;
      mask_b_q   <= mask_b_d;
    end
  end

  // flags and interrupt
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      safe_t_q <= 8'h00;
      safe_l_q <= 8'h00;
      irq_st_q <= `RST_IRQ;
      irq_en_q <= `RST_IRQ;
      irq      <= 1'b0;
    end else begin
      safe_t_q <= safe_t_d;
      safe_l_q <= safe_l_d;
      irq_st_q <= irq_st_d;
      irq_en_q <= irq_en_d;
      irq      <= irq_d;
    end
  end

  // charge-switch drive; an immediate turn-off is taken on the edge that sees the fault, a deferred one on the edge that sees a tick
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      defer_q <= 1'b0;
      off_q   <= 1'b0;
    end else begin
      defer_q <= defer_d;
      off_q   <= off_d;
    end
  end

  assign hrdata            = hrdata_q;
  assign hreadyout         = hready_q;
  assign hresp             = hresp_q;
  assign safety_temp       = safe_t_q;
  assign safety_latch      = safe_l_q;
  assign charge_switch_off = off_q;

  // helper: cycles a selected mask-a fault has waited for the switch
  logic [24:0] wait_cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_cnt <= 25'h000_0000;
    end else if (|hit_a && !off_q) begin
      wait_cnt <= wait_cnt + 25'h000_0001;
    end else begin
      wait_cnt <= 25'h000_0000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_flag_set: assert property (
    (fault_temp[3'd7] && temp_en_q[3'd7]) |=> safety_temp[3'd7])
    else $error("enabled fault did not set its flag");

  chk_flag_disabled: assert property (
    ##1 ((safety_temp & ~$past(temp_en_q)) == 8'h00 && (safety_latch & ~$past(latch_en_q)) == 8'h00))
    else $error("disabled protection set a flag");

  chk_enable_no_switch: assert property (
    (mask_a_q == 8'h00 && mask_b_q == 8'h00 && !defer_q) |=> !charge_switch_off)
    else $error("switch turned off with no mask bit set");

  chk_temp_reserved: assert property (
    temp_en_q[3] == 1'b0)
    else $error("temperature enable reserved bit set");

  chk_latch_reserved: assert property (
    latch_en_q[3] == 1'b0 && latch_en_q[0] == 1'b0)
    else $error("latch enable reserved bit set");

  chk_mask_a_off: assert property (
    (fast_mask && fault_current[`BIT_CELL_OVERVOLTAGE] && mask_a_q[`BIT_CELL_OVERVOLTAGE]) |=> charge_switch_off)
    else $error("mask a fault missed the switch");

  chk_fast_mask_off: assert property (
    ((mask_a_q == 8'h98 || mask_a_q == 8'h18) && |(fault_current & mask_a_q)) |=> charge_switch_off)
    else $error("fast mask did not turn off at once");

  chk_defer_bound: assert property (
    wait_cnt <= {1'b0, SLEEP_CYC} + 25'h000_0002)
    else $error("deferred turn-off too late");

  chk_mask_b_off: assert property (
    |(fault_temp & temp_en_q & mask_b_q) |=> charge_switch_off)
    else $error("mask b fault missed the switch");

  chk_bit_alone: assert property (
    (fast_mask && fault_current == 8'h10 && mask_a_q[`BIT_CHARGE_OVERCURRENT]) |=> charge_switch_off)
    else $error("single mask bit did not act alone");

  chk_reserved_read: assert property (
    ((mask_a_q & ~8'h98) == 8'h00) && ((mask_b_q & ~8'hD5) == 8'h00))
    else $error("mask reserved bit held a one");

  chk_latch_flag_set: assert property (
    (fault_latch[3'd6] && latch_en_q[3'd6]) |=> safety_latch[3'd6])
    else $error("enabled latch fault did not set its flag");

  chk_flag_follows: assert property (
    !fault_temp[3'd7] |=> !safety_temp[3'd7])
    else $error("flag stayed without its fault");

  chk_irq_level: assert property (
    irq == |(irq_st_q & irq_en_q))
    else $error("interrupt level disagrees with enabled status");

  chk_set_wins: assert property (
    (events[7] && irq_clr[7]) |=> irq_st_q[7])
    else $error("clear beat a new event");

  chk_mask_a_short: assert property (
    (fast_mask && fault_current[`BIT_DISCHARGE_SHORT] && mask_a_q[`BIT_DISCHARGE_SHORT]) |=> charge_switch_off)
    else $error("short circuit fault missed the switch");

  chk_defer_tick: assert property (
    (tick && !fast_mask && |(fault_current & mask_a_q)) |=> charge_switch_off)
    else $error("deferred turn-off missed its scan tick");

  chk_mask_b_reserved: assert property (
    (fault_temp == 8'h20 && fault_current == 8'h00) |=> !charge_switch_off)
    else $error("reserved mask b position cut the switch");

  chk_no_fault_on: assert property (
    (!(|(fault_current & mask_a_q)) && !(|(fault_temp & temp_en_q & mask_b_q))) |=> !charge_switch_off)
    else $error("switch turned off with no selected fault");

  chk_flags_reserved: assert property (
    safety_temp[3] == 1'b0 && safety_latch[3] == 1'b0 && safety_latch[0] == 1'b0)
    else $error("reserved safety flag position set");
endmodule

/* File: protection_enable_and_switch_masks_tb_top.sv */
/*
  self-checking bench for the protection enable and charge-switch mask bank.
  assumes: protect_pkg and protect_bank are compiled first; hready loops back from hreadyout.
*/
`timescale 1ns/1ns
`include "protect_params.svh"
module protection_enable_and_switch_masks_tb_top;
  import protect_pkg::*;
  // short scan periods keep the deferred path quick
  localparam int NCYC = 20;
  localparam int SCYC = 50;
  logic        clk;
  logic        reset_n;
  logic        hsel;
  logic [31:0] haddr;
  htrans_t     htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire logic   hready;
  logic [31:0] hrdata;
  logic        hresp;
  field_t      fault_current;
  field_t      fault_temp;
  field_t      fault_latch;
  logic        sleep_mode;
  field_t      safety_temp;
  field_t      safety_latch;
  logic        charge_switch_off;
  logic        irq;
  int          miscompares;
  int          n_compared;
  // register offsets and writable masks, walked as a table
  logic [7:0]  ofs [4] = '{`OFS_TEMP_EN, `OFS_LATCH_EN, `OFS_CHG_MASK_A, `OFS_CHG_MASK_B};
  logic [7:0]  msk [4] = '{8'hf7, 8'hf6, 8'h98, 8'hd5};

  protect_bank #(.NORMAL_CYC(24'(NCYC)), .SLEEP_CYC(24'(SCYC))) uut (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .fault_current(fault_current), .fault_temp(fault_temp), .fault_latch(fault_latch),
    .sleep_mode(sleep_mode), .safety_temp(safety_temp), .safety_latch(safety_latch),
    .charge_switch_off(charge_switch_off), .irq(irq));

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // one comparison, four-state exact
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // single ahb-lite word transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= 32'(a);
    htrans <= HT_NONSEQ;
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= HT_IDLE;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    chk(what, x, exp);
    chk("hresp okay", hresp, 32'h0000_0000);
  endtask

  // triggers land at once, outputs register at the next edge; the second edge is spare
  task automatic faults(input logic [7:0] c, input logic [7:0] t, input logic [7:0] l);
    fault_current <= c;
    fault_temp <= t;
    fault_latch <= l;
    repeat (2) @(posedge clk);
  endtask

  task automatic complete_run;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // hang guard, well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run;
  end

  // main sequence
  initial begin
    logic [7:0] te, le, ft, fl, mb, ma;
    int         n;
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = HT_IDLE;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    fault_current = 8'h00;
    fault_temp = 8'h00;
    fault_latch = 8'h00;
    sleep_mode = 1'b0;
    miscompares = 0;
    n_compared = 0;
    void'($urandom(32'hd463f811));
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    // reset values and an unmapped place
    rdc("temp_en reset", `OFS_TEMP_EN, 32'h0000_0000);
    rdc("latch_en reset", `OFS_LATCH_EN, 32'h0000_0000);
    rdc("mask_a reset", `OFS_CHG_MASK_A, 32'h0000_0098);
    rdc("mask_b reset", `OFS_CHG_MASK_B, 32'h0000_00d5);
    rdc("unmapped", 8'h40, 32'h0000_0000);
    // random read-back, reserved bits must read zero
    for (int i = 0; i < 6; i++) begin
      for (int k = 0; k < 4; k++) begin
        te = 8'($urandom);
        wr(ofs[k], {24'($urandom), te});
        rdc("rw readback", ofs[k], 32'(te & msk[k]));
      end
    end
    // enables gate flags; enables alone never cut the switch
    for (int i = 0; i < 8; i++) begin
      te = 8'($urandom);
      le = 8'($urandom);
      ft = 8'($urandom);
      fl = 8'($urandom);
      wr(`OFS_TEMP_EN, 32'(te));
      wr(`OFS_LATCH_EN, 32'(le));
      wr(`OFS_CHG_MASK_B, 32'h0000_0000);
      wr(`OFS_CHG_MASK_A, 32'h0000_0000);
      faults(8'($urandom), ft, fl);
      chk("safety_temp", safety_temp, 32'(ft & te & 8'hf7));
      chk("safety_latch", safety_latch, 32'(fl & le & 8'hf6));
      chk("off by enable", charge_switch_off, 32'h0000_0000);
      rdc("safety reg", `OFS_SAFETY, {16'h0000, fl & le & 8'hf6, ft & te & 8'hf7});
    end
    faults(8'h00, 8'h00, 8'h00);
    // immediate masks, each bit on its own
    for (int m = 0; m < 2; m++) begin
      ma = (m == 0) ? 8'h98 : 8'h18;
      wr(`OFS_CHG_MASK_A, 32'(ma));
      foreach (msk[b]) begin
        n = (b == 0) ? 7 : (b == 1) ? 4 : 3;
        if (b < 3) begin
          faults(8'(1 << n), 8'h00, 8'h00);
          chk("off fast", charge_switch_off, 32'(ma[n]));
          faults(8'h00, 8'h00, 8'h00);
        end
      end
    end
    // temperature mask, every bit alone against a random mask
    mb = 8'($urandom);
    wr(`OFS_TEMP_EN, 32'h0000_00f7);
    wr(`OFS_CHG_MASK_B, 32'(mb));
    for (int b = 0; b < 8; b++) begin
      faults(8'h00, 8'(1 << b), 8'h00);
      chk("off temp", charge_switch_off, 32'(mb[b] & (b != 5) & (b != 3) & (b != 1)));
    end
    faults(8'h00, 8'h00, 8'h00);
    // other mask a values may defer, but only up to one scan period
    wr(`OFS_CHG_MASK_A, 32'h0000_0008);
    for (int s = 0; s < 2; s++) begin
      sleep_mode <= s[0];
      fault_current <= 8'h08;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (charge_switch_off !== 1'b1 && n < SCYC + 10);
      chk("defer bound", 32'(n <= ((s == 1) ? SCYC : NCYC) + 2), 32'h0000_0001);
      faults(8'h00, 8'h00, 8'h00);
    end
    // interrupt: raise, mask, clear while the fault still holds
    wr(`OFS_IRQ_CLEAR, 32'h0000_ffff);
    wr(`OFS_IRQ_ENABLE, 32'h0000_0080);
    faults(8'h00, 8'h80, 8'h00);
    @(posedge clk);
    chk("irq raised", irq, 32'h0000_0001);
    rdc("irq status", `OFS_IRQ_STATUS, 32'h0000_0080);
    wr(`OFS_IRQ_ENABLE, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk("irq masked", irq, 32'h0000_0000);
    wr(`OFS_IRQ_CLEAR, 32'h0000_0080);
    rdc("irq cleared", `OFS_IRQ_STATUS, 32'h0000_0000);
    faults(8'h00, 8'h00, 8'h00);
    complete_run;
  end
endmodule
